// ===== logic/mptb_pkg.sv
// Summary of operation
// - the time base counts only while timebase_on, bit 15, is set
// - output_postscale code n divides the update events by n plus one
// - mode 10 counts up to period and back down, updating only at bottom
// - output edges are placed with half a time base tick resolution, half an instruction cycle at 1:1 prescale
// - every generator drives a pin pair, complementary or independent
// - complementary pairs get a programmable dead time at each swap
// - six-output variant has 3/1/1, eight-output 4/2/2 generators/faults/dead times
// - duty updates act at once or only at the period update point
// - a trigger pulse starts a conversion at a chosen point in the period
// - each output pin has its own enable
// - an override register forces pin states in place of the waveform
// - an active fault input drives the pins to programmed states
// - pin polarity comes from configuration bits caught at reset
// - count register bit 15 reads one while counting down
// - trigger fires when count equals compare and direction matches
package mptb_pkg;
  // register byte addresses on the apb
  localparam logic [7:0] ADDR_TBCTL  = 8'h00;
  localparam logic [7:0] ADDR_TBCNT  = 8'h04;
  localparam logic [7:0] ADDR_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_TRIG   = 8'h0c;
  localparam logic [7:0] ADDR_PINCTL = 8'h10;
  localparam logic [7:0] ADDR_UPDCTL = 8'h14;
  localparam logic [7:0] ADDR_DEADT  = 8'h18;
  localparam logic [7:0] ADDR_FAULT  = 8'h1c;
  localparam logic [7:0] ADDR_OVRD   = 8'h20;
  localparam logic [7:0] ADDR_DUTY0  = 8'h24;
  // field positions and dead time width
  localparam int BIT_ON    = 15;
  localparam int BIT_IDLE  = 13;
  localparam int POST_LSB  = 4;
  localparam int PRE_LSB   = 2;
  localparam int BIT_DIR   = 15;
  localparam int HI_LSB    = 4;
  localparam int OVEN_LSB  = 8;
  localparam int FEN_LSB   = 8;
  localparam int MODE_LSB  = 8;
  localparam int DT_W      = 6;
  // reset values and control write mask
  localparam logic [15:0] TBCTL_RST = 16'h0000;
  localparam logic [15:0] TBCTL_WMSK = 16'ha0ff;
  localparam logic [7:0]  PIN_ON    = 8'hff;
  // timing: one clock is half an instruction cycle
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TCY_PS        = 50000;
  localparam int CLK_PER_TCY   = TCY_PS / CLK_PERIOD_PS;
  localparam logic [7:0] PRE_LIM0 = 8'(CLK_PER_TCY * 1 - 1);
  localparam logic [7:0] PRE_LIM1 = 8'(CLK_PER_TCY * 4 - 1);
  localparam logic [7:0] PRE_LIM2 = 8'(CLK_PER_TCY * 16 - 1);
  localparam logic [7:0] PRE_LIM3 = 8'(CLK_PER_TCY * 64 - 1);
  // counting modes in field order
  typedef enum logic [1:0] {MODE_FREE, MODE_SINGLE, MODE_CENTER, MODE_CENTER_DBL} mptb_mode_t;
endpackage : mptb_pkg

// ===== logic/mptb_pair_if.sv
`timescale 1ns/1ps
interface mptb_pair_if;
  logic                          raw;
  logic                          indep;
  logic [mptb_pkg::DT_W-1:0]     dead;
  logic                          hi;
  logic                          lo;
  modport drive (output raw, indep, dead, input hi, lo);
  modport pair  (input raw, indep, dead, output hi, lo);
endinterface : mptb_pair_if

// ===== logic/mptb_pair.sv
`timescale 1ns/1ps
module mptb_pair (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // generator side
  mptb_pair_if.pair p
);
  logic                      prev_q, prev_d;
  logic [mptb_pkg::DT_W-1:0] dtCnt_q, dtCnt_d;

  // any swap of the raw wave reloads the dead time, both pins of a complementary pair stay off meanwhile
  always_comb begin
    prev_d  = p.raw;
    dtCnt_d = dtCnt_q;
    if (p.raw != prev_q) begin
      dtCnt_d = p.dead;
    end else if (dtCnt_q != '0) begin
      dtCnt_d = dtCnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q  <= 1'b0;
      dtCnt_q <= '0;
    end else begin
      prev_q  <= prev_d;
      dtCnt_q <= dtCnt_d;
    end
  end

  // independent pairs follow the wave on both pins, no dead time there
  assign p.hi = p.indep ? p.raw : (prev_q && dtCnt_q == '0);
  assign p.lo = p.indep ? p.raw : (!prev_q && dtCnt_q == '0);

  property p_deadGap;
    @(posedge ref_clk) disable iff (!resetn)
    (!p.indep && p.raw != prev_q && p.dead != '0) |=> (!p.hi && !p.lo);
  endproperty
  a_deadGap: assert property (p_deadGap) else $error("dead time gap missing");
endmodule : mptb_pair

// ===== logic/mptb_scale.sv
`timescale 1ns/1ps
module mptb_scale (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // prescale side
  input  wire logic       run,
  input  wire logic [1:0] preSel,
  output logic            tick,
  output logic            half,
  // postscale side
  input  wire logic       evt,
  input  wire logic [3:0] postSel,
  output logic            postEvt_q
);
  logic [7:0] preCnt_q, preCnt_d, preLim;
  logic [3:0] postCnt_q, postCnt_d;
  logic       postEvt_d;

  // prescale divider, frozen while the time base is stopped
  always_comb begin
    unique case (preSel)
      2'b00: preLim = mptb_pkg::PRE_LIM0;
      2'b01: preLim = mptb_pkg::PRE_LIM1;
      2'b10: preLim = mptb_pkg::PRE_LIM2;
      2'b11: preLim = mptb_pkg::PRE_LIM3;
    endcase
    tick     = run && preCnt_q >= preLim;
    half     = preCnt_q > (preLim >> 1);
    preCnt_d = !run ? preCnt_q : (tick ? 8'h00 : preCnt_q + 8'h01);
    postEvt_d = 1'b0;
    postCnt_d = postCnt_q;
    if (evt) begin
      if (postCnt_q >= postSel) begin
        postEvt_d = 1'b1;
        postCnt_d = 4'h0;
      end else begin
        postCnt_d = postCnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      preCnt_q  <= 8'h00;
      postCnt_q <= 4'h0;
      postEvt_q <= 1'b0;
    end else begin
      preCnt_q  <= preCnt_d;
      postCnt_q <= postCnt_d;
      postEvt_q <= postEvt_d;
    end
  end

  property p_post;
    @(posedge ref_clk) disable iff (!resetn)
    (evt && postCnt_q == postSel) |=> postEvt_q;
  endproperty
  a_post: assert property (p_post) else $error("postscale event missing");

  property p_pre4;
    @(posedge ref_clk) disable iff (!resetn)
    (tick && preSel == 2'b01 && $stable(preSel)) |=> !tick [*7];
  endproperty
  a_pre4: assert property (p_pre4) else $error("prescale 1:4 early tick");
endmodule : mptb_scale

// ===== logic/mptb_top.sv
`timescale 1ns/1ps
module mptb_top #(
  parameter int NGEN = 4,
  parameter int NFLT = (NGEN == 4) ? 2 : 1
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            resetn,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // device state and configuration word
  input  wire logic            cpuIdle,
  input  wire logic            devCfgHighPol,
  input  wire logic            devCfgLowPol,
  input  wire logic            devCfgPinsOn,
  input  wire logic [NFLT-1:0] faultN,
  // gate drive and events
  output logic [NGEN-1:0]      pwmHigh,
  output logic [NGEN-1:0]      pwmHighOe,
  output logic [NGEN-1:0]      pwmLow,
  output logic [NGEN-1:0]      pwmLowOe,
  output logic                 adcTrigger,
  output logic                 tbEvent
);
  localparam int NDT = NFLT;

  logic [15:0] ctl_q, ctl_d, trig_q, trig_d, ovr_q, ovr_d;
  logic [14:0] cnt_q, cnt_d, per_q, per_d, cntTb;
  logic        dir_q, dir_d, dirTb, clrOn, updEvt, updImm_q, updImm_d;
  logic [7:0]  pinEn_q, pinEn_d, pinSt;
  logic [3:0]  pairInd_q, pairInd_d;
  logic [11:0] dt_q, dt_d;
  logic [9:0]  flt_q, flt_d;
  logic [15:0] dutyShd_q [NGEN];
  logic [15:0] dutyShd_d [NGEN];
  logic [15:0] dutyAct_q [NGEN];
  logic [15:0] dutyAct_d [NGEN];
  logic        cfgDone_q, polHi_q, polLo_q;
  logic [31:0] rdata, prdata_d;
  logic        hit, acc, wrCtl, wrCnt, pready_d, pslverr_d, adcTrig_d;
  logic        run, tick, half, faultAct;
  logic [NGEN-1:0] genHi, genLo, pwmHigh_d, pwmLow_d;
  mptb_pkg::mptb_mode_t mode;

  assign mode = mptb_pkg::mptb_mode_t'(ctl_q[1:0]);
  // idle only stops the count when the halt option is chosen
  assign run  = ctl_q[mptb_pkg::BIT_ON] && !(ctl_q[mptb_pkg::BIT_IDLE] && cpuIdle);

  mptb_scale u_scale (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .run       (run),
    .preSel    (ctl_q[mptb_pkg::PRE_LSB +: 2]),
    .tick      (tick),
    .half      (half),
    .evt       (updEvt),
    .postSel   (ctl_q[mptb_pkg::POST_LSB +: 4]),
    .postEvt_q (tbEvent)
  );

  // one pair engine per generator, dead time shared round the generators
  for (genvar g = 0; g < NGEN; g++) begin : g_pair
    mptb_pair_if pif ();
    assign pif.raw   = {cnt_q, half} < dutyAct_q[g];
    assign pif.indep = pairInd_q[g];
    assign pif.dead  = dt_q[(g % NDT) * mptb_pkg::DT_W +: mptb_pkg::DT_W];
    assign genHi[g]  = pif.hi;
    assign genLo[g]  = pif.lo;
    mptb_pair u_pair (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .p       (pif.pair)
    );
  end

  // time base step; a period of zero parks the counter at zero
  always_comb begin
    cntTb  = cnt_q;
    dirTb  = dir_q;
    clrOn  = 1'b0;
    updEvt = 1'b0;
    if (tick) begin
      unique case (mode)
        mptb_pkg::MODE_FREE, mptb_pkg::MODE_SINGLE: begin
          dirTb = 1'b0;
          if (cnt_q >= per_q) begin
            cntTb  = 15'h0000;
            updEvt = 1'b1;
            clrOn  = (mode == mptb_pkg::MODE_SINGLE);
          end else begin
            cntTb = cnt_q + 15'h0001;
          end
        end
        mptb_pkg::MODE_CENTER, mptb_pkg::MODE_CENTER_DBL: begin
          if (!dir_q) begin
            if (cnt_q >= per_q) begin
              dirTb  = (per_q != 15'h0000);
              cntTb  = (per_q != 15'h0000) ? cnt_q - 15'h0001 : 15'h0000;
              updEvt = (mode == mptb_pkg::MODE_CENTER_DBL);
            end else begin
              cntTb = cnt_q + 15'h0001;
            end
          end else if (cnt_q == 15'h0000) begin
            dirTb  = 1'b0;
            cntTb  = (per_q != 15'h0000) ? 15'h0001 : 15'h0000;
            updEvt = 1'b1;
          end else begin
            cntTb = cnt_q - 15'h0001;
          end
        end
      endcase
    end
  end

  // register file and apb answer; reads latched in setup, writes at completion
  always_comb begin
    acc       = psel && penable && pready;
    rdata     = 32'h0000_0000;
    hit       = 1'b1;
    unique case (paddr)
      mptb_pkg::ADDR_TBCTL:  rdata[15:0] = ctl_q;
      mptb_pkg::ADDR_TBCNT:  rdata[15:0] = {dir_q, cnt_q};
      mptb_pkg::ADDR_PERIOD: rdata[15:0] = {1'b0, per_q};
      mptb_pkg::ADDR_TRIG:   rdata[15:0] = trig_q;
      mptb_pkg::ADDR_PINCTL: rdata[15:0] = {4'h0, pairInd_q, pinEn_q};
      mptb_pkg::ADDR_UPDCTL: rdata[0]    = updImm_q;
      mptb_pkg::ADDR_DEADT:  rdata[11:0] = dt_q;
      mptb_pkg::ADDR_FAULT:  rdata[9:0]  = flt_q;
      mptb_pkg::ADDR_OVRD:   rdata[15:0] = ovr_q;
      default:               hit         = 1'b0;
    endcase
    for (int i = 0; i < NGEN; i++) begin
      if (paddr == mptb_pkg::ADDR_DUTY0 + 8'(4 * i)) begin
        rdata[15:0] = dutyShd_q[i];
        hit         = 1'b1;
      end
    end
    pready_d  = psel && !penable;
    pslverr_d = psel && !penable && !hit;
    prdata_d  = (psel && !penable) ? rdata : prdata;
    wrCtl     = acc && pwrite && paddr == mptb_pkg::ADDR_TBCTL;
    wrCnt     = acc && pwrite && paddr == mptb_pkg::ADDR_TBCNT;
    ctl_d     = clrOn ? (ctl_q & ~(16'h0001 << mptb_pkg::BIT_ON)) : ctl_q;
    cnt_d     = cntTb;
    dir_d     = dirTb;
    per_d     = per_q;
    trig_d    = trig_q;
    pinEn_d   = cfgDone_q ? pinEn_q : (devCfgPinsOn ? mptb_pkg::PIN_ON : 8'h00);
    pairInd_d = pairInd_q;
    updImm_d  = updImm_q;
    dt_d      = dt_q;
    flt_d     = flt_q;
    ovr_d     = ovr_q;
    // immediate mode copies the shadow every cycle, else only at update points
    for (int i = 0; i < NGEN; i++) begin
      dutyShd_d[i] = dutyShd_q[i];
      dutyAct_d[i] = (updImm_q || updEvt) ? dutyShd_q[i] : dutyAct_q[i];
    end
    if (acc && pwrite && hit) begin
      unique case (paddr)
        mptb_pkg::ADDR_TBCTL:  ctl_d = pwdata[15:0] & mptb_pkg::TBCTL_WMSK;
        mptb_pkg::ADDR_TBCNT:  cnt_d = pwdata[14:0];
        mptb_pkg::ADDR_PERIOD: per_d = pwdata[14:0];
        mptb_pkg::ADDR_TRIG:   trig_d = pwdata[15:0];
        mptb_pkg::ADDR_PINCTL: begin
          pinEn_d   = pwdata[7:0];
          pairInd_d = pwdata[mptb_pkg::MODE_LSB +: 4];
        end
        mptb_pkg::ADDR_UPDCTL: updImm_d = pwdata[0];
        mptb_pkg::ADDR_DEADT:  dt_d = pwdata[11:0];
        mptb_pkg::ADDR_FAULT:  flt_d = pwdata[9:0];
        mptb_pkg::ADDR_OVRD:   ovr_d = pwdata[15:0];
        default: begin
          for (int i = 0; i < NGEN; i++) begin
            if (paddr == mptb_pkg::ADDR_DUTY0 + 8'(4 * i)) begin
              dutyShd_d[i] = pwdata[15:0];
            end
          end
        end
      endcase
    end
  end

  // trigger and pin chain: override, then fault, then polarity, then enable
  always_comb begin
    adcTrig_d = tick && cnt_q == trig_q[14:0] && dir_q == trig_q[mptb_pkg::BIT_DIR];
    faultAct  = |(~faultN & flt_q[mptb_pkg::FEN_LSB +: NFLT]);
    pinSt     = 8'h00;
    for (int i = 0; i < NGEN; i++) begin
      pinSt[i]                    = genLo[i];
      pinSt[mptb_pkg::HI_LSB + i] = genHi[i];
    end
    for (int b = 0; b < 8; b++) begin
      if (ovr_q[mptb_pkg::OVEN_LSB + b]) begin
        pinSt[b] = ovr_q[b];
      end
      if (faultAct) begin
        pinSt[b] = flt_q[b];
      end
    end
    for (int i = 0; i < NGEN; i++) begin
      pwmLow_d[i]  = pinEn_q[i] && (pinSt[i] == polLo_q);
      pwmHigh_d[i] = pinEn_q[mptb_pkg::HI_LSB + i]
                     && (pinSt[mptb_pkg::HI_LSB + i] == polHi_q);
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_q     <= mptb_pkg::TBCTL_RST;
      cnt_q     <= 15'h0000;
      dir_q     <= 1'b0;
      per_q     <= 15'h0000;
      trig_q    <= 16'h0000;
      pinEn_q   <= 8'h00;
      pairInd_q <= 4'h0;
      updImm_q  <= 1'b0;
      dt_q      <= 12'h000;
      flt_q     <= 10'h000;
      ovr_q     <= 16'h0000;
      for (int i = 0; i < NGEN; i++) begin
        dutyShd_q[i] <= 16'h0000;
        dutyAct_q[i] <= 16'h0000;
      end
      prdata    <= 32'h0000_0000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      adcTrigger <= 1'b0;
      pwmHigh   <= '0;
      pwmLow    <= '0;
      pwmHighOe <= '0;
      pwmLowOe  <= '0;
    end else begin
      ctl_q     <= ctl_d;
      cnt_q     <= cnt_d;
      dir_q     <= dir_d;
      per_q     <= per_d;
      trig_q    <= trig_d;
      pinEn_q   <= pinEn_d;
      pairInd_q <= pairInd_d;
      updImm_q  <= updImm_d;
      dt_q      <= dt_d;
      flt_q     <= flt_d;
      ovr_q     <= ovr_d;
      dutyShd_q <= dutyShd_d;
      dutyAct_q <= dutyAct_d;
      prdata    <= prdata_d;
      pready    <= pready_d;
      pslverr   <= pslverr_d;
      adcTrigger <= adcTrig_d;
      pwmHigh   <= pwmHigh_d;
      pwmLow    <= pwmLow_d;
      for (int i = 0; i < NGEN; i++) begin
        pwmLowOe[i]  <= pinEn_q[i];
        pwmHighOe[i] <= pinEn_q[mptb_pkg::HI_LSB + i];
      end
    end
  end

  // polarity straps are caught once, on the first edge after reset release
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfgDone_q <= 1'b0;
      polHi_q   <= 1'b1;
      polLo_q   <= 1'b1;
    end else if (!cfgDone_q) begin
      cfgDone_q <= 1'b1;
      polHi_q   <= devCfgHighPol;
      polLo_q   <= devCfgLowPol;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_stopHold;
    (!ctl_q[mptb_pkg::BIT_ON] && !wrCnt) |=> (cnt_q == $past(cnt_q));
  endproperty
  a_stopHold: assert property (p_stopHold) else $error("count moved while off");

  property p_idleHold;
    (ctl_q[mptb_pkg::BIT_IDLE] && cpuIdle && !wrCnt) |=> $stable(cnt_q) && $stable(dir_q);
  endproperty
  a_idleHold: assert property (p_idleHold) else $error("count moved in idle halt");

  property p_freeWrap;
    (tick && mode == mptb_pkg::MODE_FREE && cnt_q >= per_q && !wrCnt) |=> cnt_q == 15'h0000;
  endproperty
  a_freeWrap: assert property (p_freeWrap) else $error("free mode did not wrap");

  property p_single;
    (tick && mode == mptb_pkg::MODE_SINGLE && cnt_q >= per_q && !wrCtl)
      |=> !ctl_q[mptb_pkg::BIT_ON] ##1 !tick;
  endproperty
  a_single: assert property (p_single) else $error("single shot kept running");

  property p_turn;
    (tick && mode == mptb_pkg::MODE_CENTER && !dir_q && cnt_q >= per_q
      && per_q != 15'h0000 && !wrCnt)
      |=> dir_q && (paddr != mptb_pkg::ADDR_TBCNT || rdata[15]);
  endproperty
  a_turn: assert property (p_turn) else $error("center mode did not turn down");

  property p_trig;
    (tick && cnt_q == trig_q[14:0] && dir_q == trig_q[15]) |=> adcTrigger ##1 !adcTrigger;
  endproperty
  a_trig: assert property (p_trig) else $error("special trigger missing");

  property p_pinOff;
    !pinEn_q[0] |=> !pwmLowOe[0] && !pwmLow[0];
  endproperty
  a_pinOff: assert property (p_pinOff) else $error("disabled pin still driven");

  property p_ovr;
    (ovr_q[mptb_pkg::OVEN_LSB] && !faultAct && pinEn_q[0])
      |=> pwmLow[0] == ($past(ovr_q[0]) == polLo_q);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override not applied");

  c_single:  cover property (tick && mode == mptb_pkg::MODE_SINGLE && clrOn);
  c_dblTop:  cover property (updEvt && mode == mptb_pkg::MODE_CENTER_DBL && !dir_q);
  c_trigger: cover property (adcTrigger);
  c_fault:   cover property (faultAct && pinEn_q[0]);
endmodule : mptb_top

// ===== bench/mptb_gate_model.sv
`timescale 1ns/1ps
module mptb_gate_model #(
  parameter int N = 4
) (
  // clock
  input wire logic         ref_clk,
  // gate drive pins
  input wire logic [N-1:0] high,
  input wire logic [N-1:0] highOe,
  input wire logic [N-1:0] low,
  input wire logic [N-1:0] lowOe,
  // observations
  output int               overlap,
  output int               edges
);
  logic [N-1:0] onHigh;
  logic [N-1:0] onLow;
  logic         lastHigh_q = 1'b0;
  int           nOverlap = 0;
  int           nEdges = 0;
  assign overlap = nOverlap;
  assign edges   = nEdges;
  // a released pin is pulled low at the driver input, so only enabled levels count
  assign onHigh = high & highOe;
  assign onLow  = low & lowOe;
  // both switches of a leg on together would short the supply
  always @(posedge ref_clk) begin
    if ((onHigh & onLow) != '0) begin
      nOverlap <= nOverlap + 1;
    end
    if (onHigh[0] != lastHigh_q) begin
      nEdges <= nEdges + 1;
    end
    lastHigh_q <= onHigh[0];
  end
endmodule : mptb_gate_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic [7:0] a; logic [31:0] w, rst, r; logic e;} mptb_row_t;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r0, r1;
  logic        pready, pslverr, err;
  logic        cpuIdle = 1'b0, devCfgHighPol = 1'b1, devCfgLowPol = 1'b1, devCfgPinsOn = 1'b1;
  logic [1:0]  faultN = 2'h3;
  logic [3:0]  pwmHigh, pwmHighOe, pwmLow, pwmLowOe;
  logic        adcTrigger, tbEvent;
  int          fail_count = 0, checks = 0, overlap, edges, c, ov0, ed0;
  int          evMode[4] = '{0, 0, 2, 3};
  int          evPost[4] = '{0, 3, 0, 0};
  int          evGap[4] = '{10, 40, 16, 8};
  mptb_row_t   rows[10] = '{
    '{8'h00, 32'h0000ffff, 32'h0, 32'h0000a0ff, 1'b0},
    '{8'h08, 32'hffffffff, 32'h0, 32'h00007fff, 1'b0},
    '{8'h0c, 32'h0000ffff, 32'h0, 32'h0000ffff, 1'b0},
    '{8'h10, 32'h0000ffff, 32'h000000ff, 32'h00000fff, 1'b0},
    '{8'h14, 32'h0000ffff, 32'h0, 32'h00000001, 1'b0},
    '{8'h18, 32'h0000ffff, 32'h0, 32'h00000fff, 1'b0},
    '{8'h1c, 32'h0000ffff, 32'h0, 32'h000003ff, 1'b0},
    '{8'h20, 32'h0000ffff, 32'h0, 32'h0000ffff, 1'b0},
    '{8'h24, 32'h00001234, 32'h0, 32'h00001234, 1'b0},
    '{8'h40, 32'h00001234, 32'h0, 32'h0, 1'b1}};

  mptb_top #(.NGEN(4)) dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cpuIdle(cpuIdle), .devCfgHighPol(devCfgHighPol),
    .devCfgLowPol(devCfgLowPol), .devCfgPinsOn(devCfgPinsOn), .faultN(faultN),
    .pwmHigh(pwmHigh), .pwmHighOe(pwmHighOe), .pwmLow(pwmLow), .pwmLowOe(pwmLowOe),
    .adcTrigger(adcTrigger), .tbEvent(tbEvent));
  mptb_gate_model #(.N(4)) gates (.ref_clk(ref_clk), .high(pwmHigh), .highOe(pwmHighOe),
    .low(pwmLow), .lowOe(pwmLowOe), .overlap(overlap), .edges(edges));

  // 40 mhz clock
  always #12.5 ref_clk = ~ref_clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // one apb transfer, then an idle edge so strobes are never assigned twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, r, err);
  endtask : rd

  // edges between two successive pulses of the chosen event
  task automatic gap(input bit trg, output int g);
    int n;
    n = 0;
    g = 0;
    while ((trg ? adcTrigger : tbEvent) !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    while ((trg ? adcTrigger : tbEvent) !== 1'b1 && g < 3000) begin
      @(posedge ref_clk);
      g++;
    end
    g++;
  endtask : gap

  // read spacing of 3 edges plus the wait gives exactly 3 counts at each rate
  task automatic rate(input logic [31:0] ctl, input int step, input logic [31:0] exp);
    wr(8'h00, ctl);
    rd(8'h04, r0);
    repeat (3 * step - 3) @(posedge ref_clk);
    rd(8'h04, r1);
    check("count delta", (r1 - r0) & 32'h7fff, exp);
  endtask : rate

  // watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    foreach (rows[i]) begin
      rd(rows[i].a, r0);
      check("reset value", r0, rows[i].rst);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, r0);
      check("read back", r0, rows[i].r);
      check("slave error", 32'(err), 32'(rows[i].e));
    end
    wr(8'h20, 32'h0);
    wr(8'h1c, 32'h0);
    wr(8'h10, 32'h00ff);
    wr(8'h08, 32'h7fff);
    for (int p = 0; p < 4; p++) rate(32'h8000 | (p << 2), 2 << (2 * p), 32'd3);
    rate(32'h0000, 1, 32'd0);
    cpuIdle <= 1'b1;
    rate(32'ha000, 2, 32'd0);
    rate(32'h8000, 2, 32'd3);
    cpuIdle <= 1'b0;
    // update event spacing per mode and postscale, period 4
    wr(8'h08, 32'h4);
    for (int i = 0; i < 4; i++) begin
      wr(8'h00, 32'h8000 | (evPost[i] << 4) | evMode[i]);
      gap(1'b0, c);
      check("event gap", 32'(c), 32'(evGap[i]));
    end
    // conversion trigger at count 5 upward in a 10 count period
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h9);
    wr(8'h0c, 32'h0005);
    wr(8'h00, 32'h8000);
    gap(1'b1, c);
    check("trigger gap", 32'(c), 32'd20);
    wr(8'h0c, 32'h8005);
    c = 0;
    repeat (60) @(posedge ref_clk) c += int'(adcTrigger === 1'b1);
    check("trigger wrong dir", 32'(c), 32'd0);
    // down phase of a slow centre count
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h4);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h800e);
    repeat (760) @(posedge ref_clk);
    rd(8'h04, r0);
    check("direction", 32'(r0[15]), 32'd1);
    // one shot clears its own enable
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h8001);
    repeat (40) @(posedge ref_clk);
    rd(8'h00, r0);
    check("single shot", r0, 32'h0001);
    // new duty is held back while no update point comes, time base stopped
    wr(8'h14, 32'h0000);
    wr(8'h04, 32'h0004);
    wr(8'h18, 32'h0003);
    wr(8'h24, 32'h0005);
    repeat (3) @(posedge ref_clk);
    check("duty held", 32'(pwmHigh[0]), 32'd1);
    // complementary pairs switching with dead time must never overlap
    ov0 = overlap;
    ed0 = edges;
    wr(8'h00, 32'h8000);
    repeat (200) @(posedge ref_clk);
    check("shoot through", 32'(overlap - ov0), 32'd0);
    check("pin toggles", 32'(edges - ed0 > 4), 32'd1);
    wr(8'h10, 32'h0000);
    repeat (3) @(posedge ref_clk);
    check("pins off", {pwmHighOe, pwmLowOe, pwmHigh, pwmLow}, 32'h0);
    wr(8'h10, 32'h00ff);
    wr(8'h20, 32'hffa5);
    repeat (3) @(posedge ref_clk);
    check("override", {pwmHighOe, pwmLowOe, pwmHigh, pwmLow}, 32'hffa5);
    wr(8'h1c, 32'h013c);
    faultN <= 2'h2;
    repeat (3) @(posedge ref_clk);
    check("fault", {pwmHigh, pwmLow}, 32'h3c);
    faultN <= 2'h3;
    // polarity strap is caught only at reset
    devCfgLowPol <= 1'b0;
    resetn <= 1'b0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    devCfgLowPol <= 1'b1;
    wr(8'h20, 32'hffa5);
    repeat (3) @(posedge ref_clk);
    check("polarity", {pwmHigh, pwmLow}, 32'haa);
    stop_test();
  end
endmodule : tb_top
